//--- hdl/pmcg_pkg.sv
// Constants, types and pin-state tables of the power mode and clock gating block
package pmcg_pkg;

  // Register map (byte addresses)
  localparam int         AW             = 8;
  localparam logic [7:0] OFF_CTRL       = 8'h00;
  localparam logic [7:0] OFF_PRESCALE   = 8'h04;
  localparam logic [7:0] OFF_WAKE_MASK  = 8'h08;
  localparam logic [7:0] OFF_STATUS     = 8'h0c;

  // Control register fields
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_PSAVE_BIT = 2;
  localparam int CTRL_FNSEL_BIT = 3;

  // Prescaler: divisor minus one, largest division 64
  localparam int DIV_W   = 6;
  localparam int DIV_MAX = 64;
  localparam logic [DIV_W-1:0] DIV_RST = 6'h00;

  // Wake mask
  localparam int               WMASK_W   = 8;
  localparam logic [WMASK_W-1:0] WMASK_RST = 8'hff;

  // Status register fields
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_FLOAT_BIT = 4;
  localparam int STAT_OSC_BIT   = 5;
  localparam int STAT_CORE_BIT  = 6;
  localparam int STAT_WAKE_BIT  = 7;

  localparam int AD_W = 13;

  typedef enum logic [1:0] {
    PMCG_MODE_ACTIVE = 2'b00,
    PMCG_MODE_IDLE   = 2'b01,
    PMCG_MODE_PDOWN  = 2'b10
  } pmcg_mode_t;

  localparam pmcg_mode_t MODE_RST  = PMCG_MODE_ACTIVE;
  localparam logic       PSAVE_RST = 1'b0;
  localparam logic       FNSEL_RST = 1'b0;

  typedef enum logic [2:0] {
    ST_ACTIVE = 3'b000,
    ST_IDLE   = 3'b001,
    ST_PDOWN  = 3'b010,
    ST_WAKE   = 3'b011,
    ST_RESET  = 3'b100
  } pmcg_state_t;

  // Condition that selects a pin's output state
  typedef enum logic [2:0] {
    C_ACT  = 3'b000,
    C_HOLD = 3'b001,
    C_RST  = 3'b010,
    C_IDLE = 3'b011,
    C_PDN  = 3'b100
  } pmcg_cond_t;

  // Output state of a pin: active, retain, low, high, float, weak high
  typedef enum logic [2:0] {
    PS_Q  = 3'b000,
    PS_X  = 3'b001,
    PS_0  = 3'b010,
    PS_1  = 3'b011,
    PS_Z  = 3'b100,
    PS_WH = 3'b101
  } pmcg_pin_state_t;

  typedef struct packed {
    pmcg_pin_state_t h;
    pmcg_pin_state_t r;
    pmcg_pin_state_t i;
    pmcg_pin_state_t p;
  } pmcg_pin_tbl_t;

  localparam pmcg_pin_tbl_t TBL_AD   = '{h: PS_Z,  r: PS_Z,  i: PS_0,  p: PS_0};
  localparam pmcg_pin_tbl_t TBL_A19  = '{h: PS_Z,  r: PS_WH, i: PS_0,  p: PS_0};
  localparam pmcg_pin_tbl_t TBL_CK   = '{h: PS_Q,  r: PS_Q,  i: PS_Q,  p: PS_X};
  localparam pmcg_pin_tbl_t TBL_RO   = '{h: PS_0,  r: PS_1,  i: PS_0,  p: PS_0};
  localparam pmcg_pin_tbl_t TBL_WT   = '{h: PS_WH, r: PS_Z,  i: PS_WH, p: PS_WH};
  localparam pmcg_pin_tbl_t TBL_PORT = '{h: PS_X,  r: PS_Z,  i: PS_X,  p: PS_X};
  localparam pmcg_pin_tbl_t TBL_SER  = '{h: PS_Q,  r: PS_Z,  i: PS_Q,  p: PS_X};

endpackage

//--- hdl/pmcg_tick_if.sv
// Interface between the power controller and its prescaler
`timescale 1ns/10ps
interface pmcg_tick_if;
  logic                       ps_en;
  logic [pmcg_pkg::DIV_W-1:0] div_m1;
  logic                       tick;

  modport ctl (output ps_en, output div_m1, input tick);
  modport gen (input ps_en, input div_m1, output tick);
endinterface

//--- hdl/pmcg_prescaler.sv
// Prescaler that paces every internal clock edge
`timescale 1ns/10ps
module pmcg_prescaler
  import pmcg_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // Controller side
  pmcg_tick_if.gen tk
);

  import pmcg_pkg::*;

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic             tick;
  } pmcg_ps_st_t;

  pmcg_ps_st_t q;
  pmcg_ps_st_t d;

  // Outside powersave the tick fires every cycle, so the clocks run at half rate
  always_comb
  begin
    logic [DIV_W-1:0] limit;
    limit = tk.ps_en ? tk.div_m1 : '0;
    d = q;
    d.tick = (q.cnt >= limit);
    if (q.cnt >= limit)
      d.cnt = '0;
    else
      d.cnt = q.cnt + 6'h01;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q <= '0;
    else if (clk_en)
      q <= d;
  end

  assign tk.tick = q.tick;

endmodule

//--- hdl/pmcg_top.sv
// Power mode unit: mode control, internal clock gating and pin-state control
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/10ps
// Operation
// [R1] In active mode every internal clock runs at half the input clock rate.
// [R2] In idle mode the execution and bus clocks stop low while peripheral clocks keep running.
// [R3] In powerdown mode all internal clocks stop low and the crystal oscillator is disabled.
// [R4] In powersave the internal clocks are divided by a programmable prescaler, down to 1/64.
// [R5] Powersave combines with both idle and active mode.
// [R6] In hold, reset, idle and powerdown each output pin takes its assigned state.
// [R7] The low address/data pins float in hold and reset and drive zero in idle and powerdown.
// [R8] Holding the high address/status pin low in reset selects float-all mode; it is pulled up.
// [R9] In float-all mode every output pin floats except the crystal drive.
// [R10] A multi-function pin uses the state table of its currently selected function.
// [R11] After powerdown the device waits on the external wake timer pin before resuming.
// [R12] The clock output runs at half the input clock with 50% duty cycle.
// [R13] Software sets mode and prescaler; an enabled interrupt or reset ends idle or powerdown.
module pmcg_top
  import pmcg_pkg::*;
(
  // Clock, reset and freeze
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      clk_en,
  // APB slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [pmcg_pkg::AW-1:0]   paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  // Device events and core-side pin values
  input  wire logic                      reset_input_pin_n,
  input  wire logic                      hold_ack,
  input  wire logic [pmcg_pkg::WMASK_W-1:0] irq_request,
  input  wire logic [pmcg_pkg::AD_W-1:0] ad_core_value,
  input  wire logic                      ad_core_enable,
  input  wire logic                      a19_core_value,
  input  wire logic                      port_core_value,
  input  wire logic                      port_core_enable,
  input  wire logic                      serial_core_value,
  // Internal clocks and oscillator
  output logic                           exec_unit_clock,
  output logic                           bus_unit_clock,
  output logic                           peripheral_clock,
  output logic                           crystal_drive_enable,
  // Half rate clock output pin
  output logic                           half_rate_clock_output,
  output logic                           half_rate_clock_output_oe_n,
  // Reset output pin
  output logic                           reset_output,
  output logic                           reset_output_oe_n,
  // Low address/data pins
  output logic      [pmcg_pkg::AD_W-1:0] multiplexed_address_data_low,
  output logic      [pmcg_pkg::AD_W-1:0] multiplexed_address_data_low_oe_n,
  // High address/status/test pin
  input  wire logic                      high_address_status_test_pin_sense,
  output logic                           high_address_status_test_pin,
  output logic                           high_address_status_test_pin_oe_n,
  output logic                           high_address_status_test_pin_pullup,
  // Wake delay timer pin
  input  wire logic                      wake_delay_timer_pin_sense,
  output logic                           wake_delay_timer_pin,
  output logic                           wake_delay_timer_pin_oe_n,
  output logic                           wake_delay_timer_pin_pullup,
  // Multi-function port/serial pin
  output logic                           mux_port_pin,
  output logic                           mux_port_pin_oe_n
);

  import pmcg_pkg::*;

  typedef struct packed {
    pmcg_state_t        state;
    pmcg_mode_t         mode;
    logic               psave;
    logic               fnsel;
    logic [DIV_W-1:0]   div_m1;
    logic [WMASK_W-1:0] wake_mask;
    logic [31:0]        prdata;
    logic               float_all;
    logic               core_clk;
    logic               periph_clk;
    logic               half_clk;
    logic               osc_on;
    logic               discharge;
    logic               seen_low;
    logic [AD_W-1:0]    ad_o;
    logic [AD_W-1:0]    ad_oe_n;
    logic               a19_o;
    logic               a19_oe_n;
    logic               a19_pu;
    logic               ck_o;
    logic               ck_oe_n;
    logic               ro_o;
    logic               ro_oe_n;
    logic               wt_o;
    logic               wt_oe_n;
    logic               wt_pu;
    logic               pt_o;
    logic               pt_oe_n;
  } pmcg_main_st_t;

  pmcg_main_st_t q;
  pmcg_main_st_t d;

  pmcg_tick_if tk ();

  pmcg_prescaler u_prescaler (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .tk      (tk)
  );

  // Returns {value, oe_n, pullup} for one pin in the given state
  function automatic logic [2:0] pmcg_drive(pmcg_pin_state_t s, logic act_v, logic act_oe,
                                            logic held_v, logic held_oe_n);
    logic [2:0] r;
    r = 3'b010;
    unique case (s)
      PS_Q:    r = {act_v, ~act_oe, 1'b0};
      PS_X:    r = {held_v, held_oe_n, 1'b0};
      PS_0:    r = 3'b000;
      PS_1:    r = 3'b100;
      PS_Z:    r = 3'b010;
      PS_WH:   r = 3'b111;
      default: r = 3'b010;
    endcase
    return r;
  endfunction

  function automatic pmcg_pin_state_t pmcg_pick(pmcg_pin_tbl_t t, pmcg_cond_t c);
    pmcg_pin_state_t s;
    s = PS_Q;
    unique case (c)
      C_ACT:   s = PS_Q;
      C_HOLD:  s = t.h;
      C_RST:   s = t.r;
      C_IDLE:  s = t.i;
      C_PDN:   s = t.p;
      default: s = PS_Q;
    endcase
    return s;
  endfunction

  logic       acc;
  logic       setup;
  logic       hit;
  logic       wake;
  logic [2:0] drv;
  pmcg_cond_t cond;
  pmcg_cond_t wt_cond;

  assign acc   = psel & penable;
  assign setup = psel & ~penable;
  assign hit   = (paddr == OFF_CTRL) || (paddr == OFF_PRESCALE) ||
                 (paddr == OFF_WAKE_MASK) || (paddr == OFF_STATUS);
  assign wake  = |(irq_request & q.wake_mask);

  // Powersave only paces the clocks; the mode machine is independent of it
  assign tk.ps_en  = q.psave; // [R4] [R5]
  assign tk.div_m1 = q.div_m1; // [R4]

  // Reset ranks above hold, and hold above the power modes
  always_comb
  begin
    if (!reset_input_pin_n)
      cond = C_RST;
    else if (hold_ack)
      cond = C_HOLD;
    else if (q.state == ST_PDOWN || q.state == ST_WAKE)
      cond = C_PDN;
    else if (q.state == ST_IDLE)
      cond = C_IDLE;
    else
      cond = C_ACT;
  end

  // The wake sequence drives the timer pin low for one cycle, then it is weakly held again
  assign wt_cond = (cond == C_PDN && q.state == ST_WAKE && q.discharge) ? C_ACT : cond;

  always_comb
  begin
    logic core_run;
    logic periph_run;
    logic floating;
    core_run   = 1'b0;
    periph_run = 1'b0;
    floating   = 1'b0;
    drv        = 3'b010;
    d = q;

    // Register writes take effect in the access phase
    if (acc && pwrite && clk_en)
    begin
      unique case (paddr)
        OFF_CTRL:
        begin
          d.mode  = pmcg_mode_t'(pwdata[CTRL_MODE_LSB +: 2]); // [R13]
          d.psave = pwdata[CTRL_PSAVE_BIT]; // [R13]
          d.fnsel = pwdata[CTRL_FNSEL_BIT];
        end
        OFF_PRESCALE:  d.div_m1 = pwdata[DIV_W-1:0]; // [R13]
        OFF_WAKE_MASK: d.wake_mask = pwdata[WMASK_W-1:0];
        default:       d.div_m1 = q.div_m1;
      endcase
    end

    // Read data is registered in the setup phase, ready one cycle later
    if (setup && !pwrite)
    begin
      d.prdata = 32'h0000_0000;
      unique case (paddr)
        OFF_CTRL:
        begin
          d.prdata[CTRL_MODE_LSB +: 2] = q.mode;
          d.prdata[CTRL_PSAVE_BIT]     = q.psave;
          d.prdata[CTRL_FNSEL_BIT]     = q.fnsel;
        end
        OFF_PRESCALE:  d.prdata[DIV_W-1:0] = q.div_m1;
        OFF_WAKE_MASK: d.prdata[WMASK_W-1:0] = q.wake_mask;
        OFF_STATUS:
        begin
          d.prdata[STAT_STATE_LSB +: 3] = q.state;
          d.prdata[STAT_FLOAT_BIT]      = q.float_all;
          d.prdata[STAT_OSC_BIT]        = q.osc_on;
          d.prdata[STAT_CORE_BIT]       = q.core_clk;
          d.prdata[STAT_WAKE_BIT]       = wake;
        end
        default:       d.prdata = 32'h0000_0000;
      endcase
    end

    // Mode sequencing
    unique case (q.state)
      ST_RESET:
      begin
        d.float_all = ~high_address_status_test_pin_sense; // [R8]
        if (reset_input_pin_n)
          d.state = ST_ACTIVE;
      end
      ST_ACTIVE:
      begin
        if (q.mode == PMCG_MODE_IDLE)
          d.state = ST_IDLE;
        else if (q.mode == PMCG_MODE_PDOWN)
          d.state = ST_PDOWN;
      end
      ST_IDLE:
      begin
        if (wake)
        begin
          d.mode  = PMCG_MODE_ACTIVE; // [R13]
          d.state = ST_ACTIVE;
        end
        else if (q.mode == PMCG_MODE_PDOWN)
          d.state = ST_PDOWN;
        else if (q.mode != PMCG_MODE_IDLE)
          d.state = ST_ACTIVE;
      end
      ST_PDOWN:
      begin
        if (wake)
        begin
          d.mode      = PMCG_MODE_ACTIVE; // [R13]
          d.state     = ST_WAKE;
          d.discharge = 1'b1; // [R11]
          d.seen_low  = 1'b0;
        end
      end
      ST_WAKE:
      begin
        // Discharge the timing capacitor float_all_test_mode, then wait for it to charge
        d.discharge = 1'b0;
        if (!q.discharge && !wake_delay_timer_pin_sense)
          d.seen_low = 1'b1; // [R11]
        if (q.seen_low && wake_delay_timer_pin_sense)
          d.state = ST_ACTIVE; // [R11]
      end
      default: d.state = ST_RESET;
    endcase

    if (!reset_input_pin_n)
    begin
      d.state     = ST_RESET; // [R13]
      d.mode      = MODE_RST;
      d.discharge = 1'b0;
    end

    // Clocks change only on a prescaler tick and stop only low, after a full high phase
    core_run   = (q.state == ST_ACTIVE) || (q.state == ST_RESET); // [R2]
    periph_run = core_run || (q.state == ST_IDLE); // [R2] [R3]
    if (tk.tick)
    begin
      d.core_clk   = core_run ? ~q.periph_clk : 1'b0; // [R1] [R2] [R4]
      d.periph_clk = periph_run ? ~q.periph_clk : 1'b0; // [R1] [R3] [R4]
    end
    d.osc_on = !(q.state == ST_PDOWN && !q.core_clk && !q.periph_clk); // [R3]

    // Pin clock output is never prescaled; it freezes only in powerdown and the wake sequence that follows it
    d.half_clk = (cond == C_PDN) ? q.half_clk : ~q.half_clk; // [R12]

    // Pin states
    for (int b = 0; b < AD_W; b++)
    begin
      drv = pmcg_drive(pmcg_pick(TBL_AD, cond), ad_core_value[b], ad_core_enable,
                       q.ad_o[b], q.ad_oe_n[b]); // [R6] [R7]
      d.ad_o[b]    = drv[2];
      d.ad_oe_n[b] = drv[1];
    end
    drv = pmcg_drive(pmcg_pick(TBL_A19, cond), a19_core_value, 1'b1, q.a19_o, q.a19_oe_n);
    {d.a19_o, d.a19_oe_n, d.a19_pu} = drv; // [R6] [R8]
    drv = pmcg_drive(pmcg_pick(TBL_CK, cond), d.half_clk, 1'b1, q.ck_o, q.ck_oe_n);
    {d.ck_o, d.ck_oe_n} = drv[2:1]; // [R6] [R12]
    drv = pmcg_drive(pmcg_pick(TBL_RO, cond), 1'b0, 1'b1, q.ro_o, q.ro_oe_n);
    {d.ro_o, d.ro_oe_n} = drv[2:1]; // [R6]
    drv = pmcg_drive(pmcg_pick(TBL_WT, wt_cond), 1'b0, q.discharge, q.wt_o, q.wt_oe_n);
    {d.wt_o, d.wt_oe_n, d.wt_pu} = drv; // [R6] [R11]
    if (q.fnsel)
      drv = pmcg_drive(pmcg_pick(TBL_SER, cond), serial_core_value, 1'b1,
                       q.pt_o, q.pt_oe_n); // [R10]
    else
      drv = pmcg_drive(pmcg_pick(TBL_PORT, cond), port_core_value, port_core_enable,
                       q.pt_o, q.pt_oe_n); // [R10]
    {d.pt_o, d.pt_oe_n} = drv[2:1];

    // Float-all applies float_all_test_mode reset is released; the crystal drive is exempt
    floating = q.float_all && reset_input_pin_n;
    if (floating)
    begin
      d.ad_oe_n  = '1; // [R9]
      d.a19_oe_n = 1'b1; // [R9]
      d.a19_pu   = 1'b0;
      d.ck_oe_n  = 1'b1; // [R9]
      d.ro_oe_n  = 1'b1; // [R9]
      d.wt_oe_n  = 1'b1; // [R9]
      d.wt_pu    = 1'b0;
      d.pt_oe_n  = 1'b1; // [R9]
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q           <= '0;
      q.state     <= ST_RESET;
      q.mode      <= MODE_RST;
      q.psave     <= PSAVE_RST;
      q.fnsel     <= FNSEL_RST;
      q.div_m1    <= DIV_RST;
      q.wake_mask <= WMASK_RST;
      q.osc_on    <= 1'b1;
      q.ad_oe_n   <= '1;
      q.a19_oe_n  <= 1'b1;
      q.a19_pu    <= 1'b1;
      q.ck_oe_n   <= 1'b1;
      q.ro_oe_n   <= 1'b1;
      q.wt_oe_n   <= 1'b1;
      q.pt_oe_n   <= 1'b1;
    end
    else if (clk_en)
      q <= d;
  end

  // Zero-wait slave; freezing the block also holds off the bus
  assign pready  = acc & clk_en;
  assign pslverr = acc & clk_en & ~hit;
  assign prdata  = q.prdata;

  assign exec_unit_clock      = q.core_clk;
  assign bus_unit_clock       = q.core_clk;
  assign peripheral_clock     = q.periph_clk;
  assign crystal_drive_enable = q.osc_on;

  assign half_rate_clock_output              = q.ck_o;
  assign half_rate_clock_output_oe_n         = q.ck_oe_n;
  assign reset_output                        = q.ro_o;
  assign reset_output_oe_n                   = q.ro_oe_n;
  assign multiplexed_address_data_low        = q.ad_o;
  assign multiplexed_address_data_low_oe_n   = q.ad_oe_n;
  assign high_address_status_test_pin        = q.a19_o;
  assign high_address_status_test_pin_oe_n   = q.a19_oe_n;
  assign high_address_status_test_pin_pullup = q.a19_pu;
  assign wake_delay_timer_pin                = q.wt_o;
  assign wake_delay_timer_pin_oe_n           = q.wt_oe_n;
  assign wake_delay_timer_pin_pullup         = q.wt_pu;
  assign mux_port_pin                        = q.pt_o;
  assign mux_port_pin_oe_n                   = q.pt_oe_n;

endmodule

//--- verif/pmcg_chk_sva.sv
// Concurrent checks on the power mode unit ports
`timescale 1ns/10ps
module pmcg_chk
  import pmcg_pkg::*;
(
  // Clock and reset
  input wire logic                           pclk,
  input wire logic                           presetn,
  input wire logic                           clk_en,
  // APB
  input wire logic                           psel,
  input wire logic                           penable,
  input wire logic [pmcg_pkg::AW-1:0]        paddr,
  input wire logic                           pslverr,
  // Device events
  input wire logic                           reset_input_pin_n,
  input wire logic                           hold_ack,
  // Clocks and pins
  input wire logic                           exec_unit_clock,
  input wire logic                           bus_unit_clock,
  input wire logic                           peripheral_clock,
  input wire logic                           crystal_drive_enable,
  input wire logic                           half_rate_clock_output,
  input wire logic                           reset_output,
  input wire logic                           reset_output_oe_n,
  input wire logic [pmcg_pkg::AD_W-1:0]      multiplexed_address_data_low_oe_n,
  input wire logic                           high_address_status_test_pin_oe_n,
  input wire logic                           high_address_status_test_pin_pullup
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_clk_out_run: assert property ((!reset_input_pin_n && clk_en) [*2] |-> $changed(half_rate_clock_output))
    else $error("clock output stopped during reset");
  chk_periph_with_core: assert property ($changed(exec_unit_clock) |-> $changed(peripheral_clock))
    else $error("core clock moved alone");
  chk_bus_with_exec: assert property (exec_unit_clock == bus_unit_clock)
    else $error("bus and execution clocks differ");
  chk_osc_off_low: assert property (!crystal_drive_enable |-> !exec_unit_clock && !peripheral_clock)
    else $error("oscillator off with a clock high");
  chk_ad_float_rst: assert property ((!reset_input_pin_n && clk_en) [*3] |-> &multiplexed_address_data_low_oe_n)
    else $error("low address pins driven in reset");
  chk_ad_float_hold: assert property ((hold_ack && reset_input_pin_n && clk_en) [*2] |-> &multiplexed_address_data_low_oe_n)
    else $error("low address pins driven in hold");
  chk_reset_out_high: assert property ((!reset_input_pin_n && clk_en) [*3] |-> reset_output && !reset_output_oe_n)
    else $error("reset output not driven high");
  chk_test_pin_pull: assert property ((!reset_input_pin_n && clk_en) [*3] |-> high_address_status_test_pin_pullup && high_address_status_test_pin_oe_n)
    else $error("test pin not weakly held high");
  chk_unmapped_err: assert property (psel && penable && clk_en && paddr > OFF_STATUS |-> pslverr)
    else $error("unmapped access without error");
endmodule
bind pmcg_top pmcg_chk u_chk (.*);

//--- verif/test_power_mode_clock_gating.sv
// Self-checking bench for the power mode unit
`timescale 1ns/10ps
module test_power_mode_clock_gating;
  import pmcg_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, serr, hold_ack = 1'b0, reset_input_pin_n = 1'b1;
  logic [WMASK_W-1:0] irq_request = '0;
  logic [AD_W-1:0] ad_core_value = '0, multiplexed_address_data_low, multiplexed_address_data_low_oe_n;
  logic ad_core_enable = 1'b1, a19_core_value = 1'b0, port_core_value = 1'b0;
  logic port_core_enable = 1'b1, serial_core_value = 1'b0, a19_low = 1'b0, tmr_low = 1'b0;
  logic exec_unit_clock, bus_unit_clock, peripheral_clock, crystal_drive_enable;
  logic half_rate_clock_output, half_rate_clock_output_oe_n, reset_output, reset_output_oe_n;
  logic high_address_status_test_pin, high_address_status_test_pin_oe_n;
  logic high_address_status_test_pin_pullup, high_address_status_test_pin_sense;
  logic wake_delay_timer_pin, wake_delay_timer_pin_oe_n, wake_delay_timer_pin_pullup;
  logic wake_delay_timer_pin_sense, mux_port_pin, mux_port_pin_oe_n;
  int err_count = 0, checks = 0, cyc = 0, seed = 83, per, hi, regm [4], dv [4] = '{0, 1, 5, 63};
  // Board pull-ups on both sense lines unless the bench holds them low
  assign high_address_status_test_pin_sense = a19_low ? 1'b0 :
    (high_address_status_test_pin_oe_n ? 1'b1 : high_address_status_test_pin);
  assign wake_delay_timer_pin_sense = tmr_low ? 1'b0 :
    (wake_delay_timer_pin_oe_n ? 1'b1 : wake_delay_timer_pin);
  always #2.5 pclk = ~pclk;
  pmcg_top dut (.*);
  task automatic give_verdict;
    if (err_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      give_verdict;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    if (a < OFF_STATUS)
      regm[a[3:2]] = d & (a == OFF_CTRL ? 32'hf : a == OFF_PRESCALE ? 32'h3f : 32'hff);
  endtask
  task automatic rdm(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
    chk(rd, regm[a[3:2]]);
  endtask
  task automatic st(input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(rd & m, e);
  endtask
  function automatic logic cv(input logic s);
    return s ? peripheral_clock : exec_unit_clock;
  endfunction
  // Period of one internal clock, rising edge to rising edge
  task automatic measure(input logic s);
    logic lv;
    while (cv(s) !== 1'b0) @(posedge pclk);
    while (cv(s) !== 1'b1) @(posedge pclk);
    per = 0;
    repeat (2)
    begin
      lv = cv(s);
      do
      begin
        @(posedge pclk);
        per++;
      end
      while (cv(s) === lv);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge pclk);
  endtask
  initial
  begin
    regm = '{0, 0, 255, 0};
    wait_n(16);
    presetn <= 1'b1;
    for (int i = 0; i < 3; i++)
      rdm(8'(i * 4));
    st(32'h3f, 32'h20);
    repeat (6)
    begin
      wr(OFF_PRESCALE, $random(seed));
      wr(OFF_WAKE_MASK, $random(seed));
      rdm(OFF_PRESCALE);
      rdm(OFF_WAKE_MASK);
    end
    wr(OFF_WAKE_MASK, 32'hff);
    wr(OFF_STATUS, 32'hff);
    apb(1'b0, 8'h10, 32'h0);
    chk({rd[30:0], serr}, 32'h1);
    st(32'h3f, 32'h20);
    wr(OFF_PRESCALE, 32'h0);
    measure(1'b0);
    chk(per, 2);
    foreach (dv[i])
    begin
      wr(OFF_PRESCALE, dv[i]);
      wr(OFF_CTRL, 32'h4);
      measure(1'b0);
      chk(per, 2 * (dv[i] + 1));
      measure(1'b1);
      chk(per, 2 * (dv[i] + 1));
    end
    // Idle with powersave, port function retains, serial function stays live
    wr(OFF_PRESCALE, 32'h1);
    wr(OFF_CTRL, 32'h5);
    wait_n(8);
    measure(1'b1);
    chk(per, 4);
    hi = 0;
    repeat (40)
    begin
      @(posedge pclk);
      if (exec_unit_clock !== 1'b0) hi++;
    end
    chk(hi, 0);
    chk({multiplexed_address_data_low, multiplexed_address_data_low_oe_n}, 0);
    port_core_value <= 1'b1;
    wait_n(3);
    chk(mux_port_pin, 1'b0);
    wr(OFF_CTRL, 32'hd);
    serial_core_value <= 1'b1;
    wait_n(3);
    chk(mux_port_pin, 1'b1);
    irq_request <= 8'h01;
    wait_n(3);
    st(32'h7, 32'h0);
    regm[0] &= 32'hc;
    rdm(OFF_CTRL);
    wr(OFF_WAKE_MASK, 32'hfe);
    wr(OFF_CTRL, 32'h1);
    wait_n(5);
    st(32'h7, 32'h1);
    wr(OFF_WAKE_MASK, 32'hff);
    wait_n(3);
    st(32'h7, 32'h0);
    irq_request <= 8'h00;
    wr(OFF_CTRL, 32'h2);
    wait_n(10);
    chk({crystal_drive_enable, exec_unit_clock, peripheral_clock}, 0);
    hi = half_rate_clock_output;
    wait_n(3);
    chk(half_rate_clock_output, hi);
    chk({multiplexed_address_data_low, multiplexed_address_data_low_oe_n}, 0);
    tmr_low <= 1'b1;
    irq_request <= 8'h80;
    wait_n(6);
    st(32'h27, 32'h23);
    chk({wake_delay_timer_pin, wake_delay_timer_pin_oe_n, wake_delay_timer_pin_pullup},
        3'b111);
    tmr_low <= 1'b0;
    irq_request <= 8'h00;
    wait_n(4);
    st(32'h7, 32'h0);
    wr(OFF_CTRL, 32'h0);
    ad_core_value <= 13'($random(seed));
    wait_n(3);
    chk({multiplexed_address_data_low_oe_n, multiplexed_address_data_low}, ad_core_value);
    hold_ack <= 1'b1;
    wait_n(3);
    chk(multiplexed_address_data_low_oe_n, 13'h1fff);
    hold_ack <= 1'b0;
    // Reset with the test pin held low enters float-all mode
    reset_input_pin_n <= 1'b0;
    a19_low <= 1'b1;
    wait_n(6);
    chk({reset_output, reset_output_oe_n, high_address_status_test_pin_pullup,
         high_address_status_test_pin, high_address_status_test_pin_oe_n,
         mux_port_pin_oe_n}, 6'b101111);
    reset_input_pin_n <= 1'b1;
    wait_n(2);
    a19_low <= 1'b0;
    wait_n(4);
    chk({multiplexed_address_data_low_oe_n, reset_output_oe_n, half_rate_clock_output_oe_n,
         mux_port_pin_oe_n, high_address_status_test_pin_oe_n, crystal_drive_enable}, 18'h3ffff);
    st(32'h10, 32'h10);
    reset_input_pin_n <= 1'b0;
    wait_n(4);
    reset_input_pin_n <= 1'b1;
    wait_n(4);
    st(32'h37, 32'h20);
    // Freeze, then a second reset in mid-run restores the register defaults
    clk_en <= 1'b0;
    wait_n(5);
    clk_en <= 1'b1;
    wr(OFF_WAKE_MASK, 32'h0);
    presetn <= 1'b0;
    wait_n(2);
    presetn <= 1'b1;
    regm = '{0, 0, 255, 0};
    rdm(OFF_WAKE_MASK);
    give_verdict;
  end
endmodule
